// ===== rtl/uartri_top.sv
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module uartri_top import uartri_pkg::*; #(
  parameter longint CLK_HZ = CLK_HZ_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic shared_pin_rx_i,
  output logic shared_pin_tx_o,
  output logic shared_pin_tx_oe,
  output logic shared_pin_rx_o,
  output logic shared_pin_rx_oe,
  input wire logic gpio_tx_o,
  input wire logic gpio_tx_oe,
  input wire logic gpio_rx_o,
  input wire logic gpio_rx_oe,
  output logic irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  uartri_ctrl_t ctrl_q;
  logic [1:0] irq_stat_q, irq_en_q;
  logic rx_full_q, tx_full_q;
  logic [7:0] rx_buf_q, tx_shift_q, rx_shift_q;
  logic [2:0] tx_bit_q, rx_bit_q;
  uartri_tx_state_t tx_state_q;
  uartri_rx_state_t rx_state_q;
  logic [2:0] rx_sync_q;
  logic tx_line_q, rx_level_q, rx_prev_q, wr_pend_q;
  logic [31:0] wr_addr_q;
  logic [15:0] period, rd_val;
  logic acc, rd_acc, wr_ctrl, wr_data, wr_clr, wr_en, rd_data;
  logic tx_start, tx_done, rx_done, rx_restart;
  logic tx_mid, tx_end, rx_mid, rx_end;
  logic [1:0] irq_set;
  uartri_pin_t tx_pin, rx_pin;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign acc = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign rd_acc = acc && !hwrite;
  assign rd_data = rd_acc && (haddr == uartri_addr(DATA_IDX));
  assign wr_ctrl = wr_pend_q && (wr_addr_q == uartri_addr(CTRL_IDX));
  assign wr_data = wr_pend_q && (wr_addr_q == uartri_addr(DATA_IDX));
  assign wr_clr = wr_pend_q && (wr_addr_q == uartri_addr(IRQ_CLR_IDX));
  assign wr_en = wr_pend_q && (wr_addr_q == uartri_addr(IRQ_EN_IDX));

  always_comb begin
    rd_val = 16'h0000;
    if (haddr == uartri_addr(CTRL_IDX)) begin
      rd_val = ctrl_q;
    end else if (haddr == uartri_addr(STAT_IDX)) begin
      rd_val = STAT_RST;
      rd_val[STAT_TXF_BIT] = tx_full_q;
      rd_val[STAT_RXF_BIT] = rx_full_q;
    end else if (haddr == uartri_addr(DATA_IDX)) begin
      rd_val = {8'h00, rx_buf_q};
    end else if (haddr == uartri_addr(IRQ_STAT_IDX)) begin
      rd_val = {14'h0000, irq_stat_q};
    end else if (haddr == uartri_addr(IRQ_EN_IDX)) begin
      rd_val = {14'h0000, irq_en_q};
    end
  end

  // ----------------------------------------
  // Bus slave: zero wait states, always OKAY
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= acc && hwrite;
      if (acc && hwrite) begin
        wr_addr_q <= haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_acc) begin
      hrdata <= {16'h0000, rd_val};
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= {11'h000, hwdata[4:0]};
    end
  end

  // Cycles per bit from the selected rate
  assign period = uartri_period(ctrl_q.baud, ctrl_q.scale, CLK_HZ);

  // ----------------------------------------
  // Pin sharing
  // ----------------------------------------
  always_comb begin
    if (ctrl_q.enable) begin
      tx_pin = '{o: tx_line_q, oe: 1'b1};
      rx_pin = '{o: 1'b0, oe: 1'b0};
    end else begin
      tx_pin = '{o: gpio_tx_o, oe: gpio_tx_oe};
      rx_pin = '{o: gpio_rx_o, oe: gpio_rx_oe};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shared_pin_tx_o <= 1'b1;
      shared_pin_tx_oe <= 1'b0;
      shared_pin_rx_o <= 1'b0;
      shared_pin_rx_oe <= 1'b0;
    end else begin
      shared_pin_tx_o <= tx_pin.o;
      shared_pin_tx_oe <= tx_pin.oe;
      shared_pin_rx_o <= rx_pin.o;
      shared_pin_rx_oe <= rx_pin.oe;
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  assign tx_start = wr_data && ctrl_q.enable && !tx_full_q;
  assign tx_done = (tx_state_q == TX_STOP) && tx_end;

  uartri_bitclk #(
    .CW(16)
  ) u_tx_clk (
    .hclk(hclk),
    .hresetn(hresetn),
    .restart(tx_start),
    .period(period),
    .mid_tick(tx_mid),
    .end_tick(tx_end)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= '0;
      tx_bit_q <= '0;
      tx_line_q <= 1'b1;
    end else if (!ctrl_q.enable) begin
      tx_state_q <= TX_IDLE;
      tx_line_q <= 1'b1;
    end else begin
      unique case (tx_state_q)
        TX_IDLE: begin
          tx_line_q <= 1'b1;
          if (tx_start) begin
            tx_shift_q <= hwdata[7:0];
            tx_line_q <= 1'b0;
            tx_state_q <= TX_START;
          end
        end
        TX_START: begin
          if (tx_end) begin
            tx_line_q <= tx_shift_q[0];
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_bit_q <= '0;
            tx_state_q <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_end) begin
            if (tx_bit_q == 3'h7) begin
              tx_line_q <= 1'b1;
              tx_state_q <= TX_STOP;
            end else begin
              tx_line_q <= tx_shift_q[0];
              tx_shift_q <= {1'b0, tx_shift_q[7:1]};
              tx_bit_q <= tx_bit_q + 3'h1;
            end
          end
        end
        TX_STOP: begin
          if (tx_end) begin
            tx_state_q <= TX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_full_q <= 1'b0;
    end else if (tx_start) begin
      tx_full_q <= 1'b1;
    end else if (tx_done || !ctrl_q.enable) begin
      tx_full_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Receiver input synchroniser
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_sync_q <= 3'h7;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], shared_pin_rx_i};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_level_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      if (rx_sync_q[1] == rx_sync_q[2]) begin
        rx_level_q <= rx_sync_q[2];
      end
      rx_prev_q <= rx_level_q;
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  assign rx_restart = (rx_state_q == RX_IDLE) && rx_prev_q && !rx_level_q;
  assign rx_done = (rx_state_q == RX_STOP) && rx_mid && rx_level_q;

  uartri_bitclk #(
    .CW(16)
  ) u_rx_clk (
    .hclk(hclk),
    .hresetn(hresetn),
    .restart(rx_restart),
    .period(period),
    .mid_tick(rx_mid),
    .end_tick(rx_end)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_q <= RX_IDLE;
      rx_shift_q <= '0;
      rx_bit_q <= '0;
    end else if (!ctrl_q.enable) begin
      rx_state_q <= RX_IDLE;
    end else begin
      unique case (rx_state_q)
        RX_IDLE: begin
          if (rx_restart) begin
            rx_state_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_mid) begin
            rx_bit_q <= '0;
            rx_state_q <= rx_level_q ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_shift_q <= {rx_level_q, rx_shift_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7) begin
              rx_state_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_mid) begin
            rx_state_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Good stop bit loads the buffer; a new byte overwrites an unread one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_buf_q <= DATA_RST[7:0];
    end else if (rx_done) begin
      rx_buf_q <= rx_shift_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_full_q <= 1'b0;
    end else if (rx_done) begin
      rx_full_q <= 1'b1;
    end else if (rd_data) begin
      rx_full_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_comb begin
    irq_set = 2'h0;
    irq_set[IRQ_RXF_BIT] = rx_done;
    irq_set[IRQ_TXE_BIT] = tx_done;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_q <= IRQ_RST;
    end else if (wr_en) begin
      irq_en_q <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= IRQ_RST;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_clr ? hwdata[1:0] : 2'h0)) | irq_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_en_q);
    end
  end

endmodule : uartri_top
`default_nettype wire

// ===== rtl/uartri_pkg.sv
// ----------------------------------------
// Serial port package
// ----------------------------------------
package uartri_pkg;

  // ----------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------
  localparam logic [15:0] CTRL_IDX = 16'hc0e0;
  localparam logic [15:0] STAT_IDX = 16'hc0e2;
  localparam logic [15:0] DATA_IDX = 16'hc0e4;
  localparam logic [15:0] IRQ_STAT_IDX = 16'hc1f0;
  localparam logic [15:0] IRQ_CLR_IDX = 16'hc1f2;
  localparam logic [15:0] IRQ_EN_IDX = 16'hc1f4;

  // ----------------------------------------
  // Reset values and field positions
  // ----------------------------------------
  localparam logic [15:0] CTRL_RST = 16'h0007;
  localparam logic [15:0] STAT_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam int STAT_TXF_BIT = 0;
  localparam int STAT_RXF_BIT = 1;
  localparam int IRQ_TXE_BIT = 0;
  localparam int IRQ_RXF_BIT = 1;
  localparam int DATA_BITS = 8;

  // ----------------------------------------
  // Bit rates
  // ----------------------------------------
  localparam longint REF_HZ = 48000000;
  localparam longint BASE_NUM = 3;
  localparam longint BASE_DEN = 1250;
  localparam longint PRESCALE = 8;
  localparam longint CLK_HZ_DEF = 25000000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [10:0] rsvd;
    logic scale;
    logic [2:0] baud;
    logic enable;
  } uartri_ctrl_t;

  typedef struct packed {
    logic o;
    logic oe;
  } uartri_pin_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } uartri_rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b10,
    TX_STOP = 2'b11
  } uartri_tx_state_t;

  function automatic logic [31:0] uartri_addr(input logic [15:0] idx);
    return {14'h0, idx, 2'h0};
  endfunction : uartri_addr

  // Divider of the base rate REF_HZ*3/1250 for each select code
  function automatic longint uartri_rate_div(input logic [2:0] code);
    longint d;
    d = 1;
    unique case (code)
      3'h0: d = 1;
      3'h1: d = 2;
      3'h2: d = 3;
      3'h3: d = 4;
      3'h4: d = 6;
      3'h5: d = 8;
      3'h6: d = 12;
      3'h7: d = 16;
    endcase
    return d;
  endfunction : uartri_rate_div

  // Clock cycles per bit, rounded to nearest
  function automatic logic [15:0] uartri_period(input logic [2:0] code, input logic scale, input longint clk_hz);
    longint num;
    longint den;
    num = clk_hz * uartri_rate_div(code) * BASE_DEN * (scale ? PRESCALE : 1);
    den = REF_HZ * BASE_NUM;
    return 16'((num + den / 2) / den);
  endfunction : uartri_period

endpackage : uartri_pkg

// ===== rtl/uartri_bitclk.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Bit timer: mid-bit and end-of-bit ticks
// ----------------------------------------
module uartri_bitclk import uartri_pkg::*; #(
  parameter int CW = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic restart,
  input wire logic [CW-1:0] period,
  output logic mid_tick,
  output logic end_tick
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] half;

  assign half = period >> 1;
  assign end_tick = (cnt_q == period - CW'(1));
  assign mid_tick = (cnt_q == half - CW'(1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (restart || end_tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

endmodule : uartri_bitclk
`default_nettype wire

// ===== tb/uartri_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------
// Port checker
// ----------------
module uartri_checker import uartri_pkg::*; #(
  parameter longint CLK_HZ = CLK_HZ_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic shared_pin_tx_o,
  input wire logic shared_pin_tx_oe,
  input wire logic shared_pin_rx_oe,
  input wire logic irq
);
  localparam int BAUD [8] = '{115200, 57600, 38400, 28800, 19200, 14400, 9600, 7200};
  logic wr_q;
  logic rd_q;
  logic [15:0] idx_q;
  logic [4:0] ctrl_q;
  logic [1:0] ien_q;
  int cnt_q;
  wire logic acc = hsel && hready && htrans[1];
  function automatic int per(input logic [4:0] c);
    int b;
    b = BAUD[c[3:1]] / (c[4] ? 8 : 1);
    return int'((CLK_HZ + b / 2) / b);
  endfunction : per
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      idx_q <= 16'h0000;
      ctrl_q <= 5'h07;
      ien_q <= 2'h0;
      cnt_q <= 0;
    end else begin
      wr_q <= acc && hwrite;
      rd_q <= acc && !hwrite;
      idx_q <= haddr[17:2];
      if (wr_q && idx_q == CTRL_IDX) ctrl_q <= hwdata[4:0];
      if (wr_q && idx_q == IRQ_EN_IDX) ien_q <= hwdata[1:0];
      if (!ctrl_q[0]) cnt_q <= 0;
      else if (wr_q && idx_q == DATA_IDX && cnt_q == 0) cnt_q <= 10 * per(ctrl_q);
      else if (cnt_q != 0) cnt_q <= cnt_q - 1;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  port_on_a: assert property ($past(ctrl_q[0]) && $past(hresetn) |-> shared_pin_tx_oe && !shared_pin_rx_oe)
    else $error("pins not owned while enabled");
  stat_rsvd_a: assert property (rd_q && idx_q == STAT_IDX |-> hrdata[31:2] == 30'h0)
    else $error("status reserved bits set");
  data_rsvd_a: assert property (rd_q && idx_q == DATA_IDX |-> hrdata[31:8] == 24'h0)
    else $error("data upper bits set");
  ctrl_back_a: assert property (rd_q && idx_q == CTRL_IDX |-> hrdata == {27'h0, ctrl_q})
    else $error("control readback wrong");
  start_low_a: assert property ($fell(shared_pin_tx_o) && ctrl_q[0] && $past(ctrl_q[0]) |-> !shared_pin_tx_o [*8])
    else $error("start bit too short");
  irq_mask_a: assert property (ien_q == 2'h0 && $past(ien_q) == 2'h0 |-> !irq)
    else $error("irq while masked");
  txf_busy_a: assert property (rd_q && idx_q == STAT_IDX && cnt_q > 4 |-> hrdata[0])
    else $error("transmit full missing");
  txf_idle_a: assert property (rd_q && idx_q == STAT_IDX && cnt_q == 0 && $past(cnt_q, 4) == 0 |-> !hrdata[0])
    else $error("transmit full stuck");
  cover property (rd_q && idx_q == DATA_IDX);
  cover property ($rose(irq));
  cover property (cnt_q == 1);
endmodule : uartri_checker
bind uartri_top uartri_checker #(.CLK_HZ(CLK_HZ)) uartri_checker_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .shared_pin_tx_o, .shared_pin_tx_oe, .shared_pin_rx_oe, .irq);
`default_nettype wire

// ===== tb/uartri_peer.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------
// Remote serial peer
// ----------------
module uartri_peer (
  input wire logic hclk,
  input wire logic line_in,
  output logic line_out
);
  int bit_p = 217;
  int rx_count = 0;
  int low_run = 0;
  int last_low = 0;
  logic [7:0] rx_byte = 8'h00;
  logic rx_stop = 1'b0;
  initial line_out = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (bit_p) @(posedge hclk);
    end
  endtask : send
  always @(posedge hclk) begin
    if (line_in === 1'b0) low_run <= low_run + 1;
    else if (low_run != 0) begin
      last_low <= low_run;
      low_run <= 0;
    end
  end
  initial forever begin
    @(posedge hclk);
    if (line_in === 1'b0) begin
      repeat (bit_p / 2) @(posedge hclk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_p) @(posedge hclk);
        rx_byte[i] = line_in;
      end
      repeat (bit_p) @(posedge hclk);
      rx_stop = line_in;
      rx_count++;
    end
  end
endmodule : uartri_peer
`default_nettype wire

// ===== tb/uartri_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------
// Serial port bench
// ----------------
module uartri_top_tb import uartri_pkg::*;;
  localparam longint CLK = 25000000;
  logic hclk, hresetn, hsel, hwrite, gpio_tx_o, gpio_tx_oe, gpio_rx_o, gpio_rx_oe;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hreadyout, hresp, irq, tx_o, tx_oe, rx_o, rx_oe, txd, rxd, peer_out;
  wire logic [31:0] hrdata;
  int errors = 0;
  int check_count = 0;
  assign txd = tx_oe ? tx_o : 1'b1;
  assign rxd = rx_oe ? rx_o : peer_out;
  uartri_top #(.CLK_HZ(CLK)) uartri_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .shared_pin_rx_i(rxd), .shared_pin_tx_o(tx_o),
    .shared_pin_tx_oe(tx_oe), .shared_pin_rx_o(rx_o), .shared_pin_rx_oe(rx_oe), .gpio_tx_o(gpio_tx_o),
    .gpio_tx_oe(gpio_tx_oe), .gpio_rx_o(gpio_rx_o), .gpio_rx_oe(gpio_rx_oe), .irq(irq));
  uartri_peer uartri_peer_i (.hclk(hclk), .line_in(txd), .line_out(peer_out));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic give_verdict;
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic [15:0] idx, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(idx, 1'b1, d, x);
  endtask : wr
  task automatic rdchk(input string nm, input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(idx, 1'b0, 32'h0, x);
    chk(nm, x, exp);
  endtask : rdchk
  task automatic wait_tx;
    logic [31:0] x;
    x = 32'h1;
    for (int i = 0; i < 20000 && x[0] !== 1'b0; i++) bus(STAT_IDX, 1'b0, 32'h0, x);
    chk("txf drain", {31'h0, x[0]}, 32'h0);
  endtask : wait_tx
  function automatic int exp_p(input int c, input int s);
    int baud [8];
    int b;
    baud = '{115200, 57600, 38400, 28800, 19200, 14400, 9600, 7200};
    b = baud[c] / (s != 0 ? 8 : 1);
    return int'((CLK + b / 2) / b);
  endfunction : exp_p
  task automatic t_reset;
    rdchk("ctrl reset", CTRL_IDX, 32'h7);
    rdchk("status reset", STAT_IDX, 32'h0);
    rdchk("data reset", DATA_IDX, 32'h0);
    rdchk("unmapped", 16'h0100, 32'h0);
    wr(STAT_IDX, 32'h3);
    rdchk("status write", STAT_IDX, 32'h0);
    chk("okay", {31'h0, hresp}, 32'h0);
  endtask : t_reset
  task automatic t_ctrl;
    for (int i = 0; i < 16; i++) begin
      wr(CTRL_IDX, {27'h0, 4'(i), 1'b1});
      rdchk("ctrl field", CTRL_IDX, {27'h0, 4'(i), 1'b1});
    end
  endtask : t_ctrl
  task automatic t_rate(input int c, input int s);
    wr(CTRL_IDX, {27'h0, 1'(s), 3'(c), 1'b1});
    uartri_peer_i.bit_p = exp_p(c, s);
    wr(DATA_IDX, 32'hff);
    wait_tx();
    chk("bit period", uartri_peer_i.last_low, exp_p(c, s));
    chk("rate byte", {24'h0, uartri_peer_i.rx_byte}, 32'hff);
  endtask : t_rate
  task automatic t_tx;
    int n;
    wr(CTRL_IDX, 32'h1);
    uartri_peer_i.bit_p = exp_p(0, 0);
    wr(IRQ_EN_IDX, 32'h1);
    wr(IRQ_CLR_IDX, 32'h3);
    n = uartri_peer_i.rx_count;
    wr(DATA_IDX, 32'h5a);
    rdchk("txf set", STAT_IDX, 32'h1);
    wr(DATA_IDX, 32'ha5);
    wait_tx();
    chk("tx byte", {24'h0, uartri_peer_i.rx_byte}, 32'h5a);
    chk("stop bit", {31'h0, uartri_peer_i.rx_stop}, 32'h1);
    rdchk("txf clear", STAT_IDX, 32'h0);
    rdchk("tx event", IRQ_STAT_IDX, 32'h1);
    chk("irq tx", {31'h0, irq}, 32'h1);
    wr(IRQ_CLR_IDX, 32'h1);
    repeat (2400) @(posedge hclk);
    chk("irq off", {31'h0, irq}, 32'h0);
    chk("frames", uartri_peer_i.rx_count, n + 1);
  endtask : t_tx
  task automatic t_rx;
    wr(IRQ_EN_IDX, 32'h2);
    wr(IRQ_CLR_IDX, 32'h3);
    @(posedge hclk);
    uartri_peer_i.send(8'h3c);
    repeat (4) @(posedge hclk);
    rdchk("rxf set", STAT_IDX, 32'h2);
    chk("irq rx", {31'h0, irq}, 32'h1);
    rdchk("rx byte", DATA_IDX, 32'h3c);
    rdchk("rxf clear", STAT_IDX, 32'h0);
    wr(IRQ_EN_IDX, 32'h0);
    repeat (2) @(posedge hclk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(IRQ_CLR_IDX, 32'h3);
  endtask : t_rx
  task automatic t_pins;
    @(posedge hclk);
    gpio_tx_o <= 1'b0;
    gpio_tx_oe <= 1'b1;
    gpio_rx_o <= 1'b1;
    gpio_rx_oe <= 1'b1;
    wr(DATA_IDX, 32'h0);
    wr(CTRL_IDX, 32'h0);
    repeat (3) @(posedge hclk);
    chk("pins off", {28'h0, tx_o, tx_oe, rx_o, rx_oe}, 32'h7);
    rdchk("tx abort", STAT_IDX, 32'h0);
    wr(CTRL_IDX, 32'h1);
    repeat (3) @(posedge hclk);
    chk("pins on", {28'h0, tx_o, tx_oe, rx_o, rx_oe}, 32'hc);
  endtask : t_pins
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    {gpio_tx_o, gpio_tx_oe, gpio_rx_o, gpio_rx_oe} = 4'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_ctrl();
    t_rate(0, 0);
    t_rate(3, 0);
    t_rate(0, 1);
    t_tx();
    t_rx();
    t_pins();
    give_verdict();
  end
  initial begin
    repeat (90000) @(posedge hclk);
    errors++;
    give_verdict();
  end
endmodule : uartri_top_tb
`default_nettype wire
